// File: odm_defs.svh
// Timing and field constants for the odometer pulse input block
// Included by every file that needs a number; holds definitions only
`ifndef ODM_DEFS_SVH
`define ODM_DEFS_SVH
`define ODM_CLK_MHZ 100
`define ODM_MIN_LOW_TIME_US 10
`define ODM_MIN_LOW_CYCLES (`ODM_MIN_LOW_TIME_US * `ODM_CLK_MHZ)
`define ODM_MIN_CYCLE_TIME_US 1000
`define ODM_FAST_CYCLE_TIME_US 200
`define ODM_WINDOW_US 100000
`define ODM_WINDOW_CYCLES (`ODM_WINDOW_US * `ODM_CLK_MHZ)
`define ODM_BAUD 9600
`define ODM_BIT_CYCLES (`ODM_CLK_MHZ * 1000000 / `ODM_BAUD)
`define ODM_DATA_BITS 8
`define ODM_DIV_SEL_W 3
`define ODM_DIV_CNT_W 7
`define ODM_NUM_DET 3
`endif

// File: odm_pkg.sv
// Types shared by the odometer pulse input block
// Assumes odm_defs.svh is compiled alongside
package odm_pkg;
  typedef enum logic [1:0] {st_idle, st_start, st_data, st_stop} odm_uart_state_type;
endpackage : odm_pkg

// File: odm_fall_detect.sv
// Falling edge detector that re-arms only after the line is seen high
// Assumes sig_in is already synchronous to clock_in
`timescale 1ns/10ps
`include "odm_defs.svh"
module odm_fall_detect (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic sig_in,
  output logic pulse_out
);
  logic armed_q;

  // Armed stays low out of reset so a line that starts low is not counted
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      armed_q <= 1'b0;
      pulse_out <= 1'b0;
    end else begin
      armed_q <= sig_in;
      pulse_out <= armed_q & ~sig_in;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  // Reset leaves the detector disarmed, so the first sample after release is exempt
  AST_FALL_COUNTED: assert property (!$past(sys_rst_in) && $past(sig_in) && !sig_in |=> pulse_out)
    else $error("Falling edge not counted");
  AST_NO_RISE_COUNT: assert property (pulse_out |-> !$past(sig_in))
    else $error("Count without low level");
  AST_REARM_HIGH: assert property (!sig_in && !$past(sig_in) |=> !pulse_out)
    else $error("Counted again without high level");
  // One sample of low is enough, far below the shortest legal low time
  AST_LOW_RESOLVED: assert property (sig_in ##1 !sig_in ##1 sig_in |-> pulse_out)
    else $error("Short low pulse missed");
endmodule : odm_fall_detect

// File: odm_odometer_input.sv
// Odometer pulse input: counting, over-rate warning, divider, forwarding, serial line
// Assumes all pin inputs are synchronous to clock_in
`timescale 1ns/10ps
`include "odm_defs.svh"
module odm_odometer_input #(
  parameter int unsigned WINDOW_CYCLES = `ODM_WINDOW_CYCLES,
  parameter int unsigned BIT_CYCLES = `ODM_BIT_CYCLES,
  parameter int COUNT_W = 32,
  parameter int RATE_W = 16
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic odo1_in,
  input wire logic odo2_in,
  input wire logic active_sel_in,
  input wire logic fast_limit_in,
  input wire logic [`ODM_DIV_SEL_W-1:0] div_sel_in,
  input wire logic [`ODM_DATA_BITS-1:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic rx_in,
  output logic [COUNT_W-1:0] odo_count_out,
  output logic count_pulse_out,
  output logic over_rate_out,
  output logic fwd1_out,
  output logic fwd2_out,
  output logic tx_out,
  output logic tx_ready_out,
  output logic [`ODM_DATA_BITS-1:0] rx_data_out,
  output logic rx_valid_out,
  output logic rx_error_out
);
  localparam int unsigned SLOW_LIMIT = WINDOW_CYCLES / (`ODM_MIN_CYCLE_TIME_US * `ODM_CLK_MHZ);
  localparam int unsigned FAST_LIMIT = WINDOW_CYCLES / (`ODM_FAST_CYCLE_TIME_US * `ODM_CLK_MHZ);

  function automatic logic [`ODM_DIV_CNT_W-1:0] div_last(input logic [`ODM_DIV_SEL_W-1:0] sel);
    div_last = `ODM_DIV_CNT_W'((8'h01 << sel) - 8'h01);
  endfunction : div_last

  logic [`ODM_NUM_DET-1:0] det_sig;
  logic [`ODM_NUM_DET-1:0] det_pulse;
  logic [`ODM_DIV_CNT_W-1:0] div_cnt_q;
  logic [`ODM_DIV_SEL_W-1:0] div_sel_q;
  logic div_q;
  logic sel_pulse;
  logic [31:0] win_tmr_q;
  logic [RATE_W-1:0] win_cnt_q;
  logic win_end;
  logic [RATE_W-1:0] rate_limit;
  odm_pkg::odm_uart_state_type tx_st_q;
  odm_pkg::odm_uart_state_type rx_st_q;
  logic [31:0] tx_div_q;
  logic tx_tick;
  logic [2:0] tx_bit_q;
  logic [`ODM_DATA_BITS-1:0] tx_shift_q;
  logic [31:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [`ODM_DATA_BITS-1:0] rx_shift_q;

  // Detector 0: first jack, 1: raw second jack, 2: divided second jack
  assign det_sig = {div_q, odo2_in, odo1_in};

  genvar gi;
  generate
    for (gi = 0; gi < `ODM_NUM_DET; gi++) begin : g_det
      odm_fall_detect u_det (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .sig_in(det_sig[gi]),
        .pulse_out(det_pulse[gi])
      );
    end
  endgenerate

  // Sampling at the full clock rate keeps far ahead of the fastest legal source
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      div_sel_q <= '0;
      div_cnt_q <= '0;
      div_q <= 1'b1;
    end else begin
      div_sel_q <= div_sel_in;
      if (div_sel_in != div_sel_q) begin
        div_cnt_q <= '0;
      end else if (det_pulse[1]) begin
        div_cnt_q <= (div_cnt_q == div_last(div_sel_q)) ? '0 : div_cnt_q + 1'b1;
      end
      if (div_sel_in == div_sel_q && det_pulse[1] && div_cnt_q == div_last(div_sel_q)) begin
        div_q <= 1'b0;
      end else if (odo2_in) begin
        div_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      fwd1_out <= 1'b1;
      fwd2_out <= 1'b1;
    end else begin
      fwd1_out <= div_q;
      fwd2_out <= odo1_in;
    end
  end

  assign sel_pulse = active_sel_in ? det_pulse[2] : det_pulse[0];

  // One pulse per cycle at most, so the counter never loses an edge
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      odo_count_out <= '0;
      count_pulse_out <= 1'b0;
    end else begin
      count_pulse_out <= sel_pulse;
      if (sel_pulse) begin
        odo_count_out <= odo_count_out + 1'b1;
      end
    end
  end

  assign win_end = (win_tmr_q == 32'(WINDOW_CYCLES - 1));
  assign rate_limit = fast_limit_in ? RATE_W'(FAST_LIMIT) : RATE_W'(SLOW_LIMIT);

  // The warning only moves at a window boundary, so it lags the rate by one window
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      win_tmr_q <= '0;
      win_cnt_q <= '0;
      over_rate_out <= 1'b0;
    end else begin
      if (win_end) begin
        win_tmr_q <= '0;
        win_cnt_q <= sel_pulse ? RATE_W'(1) : '0;
        over_rate_out <= (win_cnt_q > rate_limit);
      end else begin
        win_tmr_q <= win_tmr_q + 32'h0000_0001;
        if (sel_pulse && !(&win_cnt_q)) begin
          win_cnt_q <= win_cnt_q + 1'b1;
        end
      end
    end
  end

  assign tx_tick = (tx_div_q == 32'(BIT_CYCLES - 1));

  always_ff @(posedge clock_in) begin
    if (sys_rst_in || tx_tick) begin
      tx_div_q <= '0;
    end else begin
      tx_div_q <= tx_div_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tx_st_q <= odm_pkg::st_idle;
      tx_out <= 1'b1;
      tx_ready_out <= 1'b0;
      tx_bit_q <= '0;
      tx_shift_q <= '0;
    end else begin
      case (tx_st_q)
        odm_pkg::st_idle: begin
          tx_out <= 1'b1;
          if (tx_valid_in && tx_ready_out) begin
            tx_shift_q <= tx_data_in;
            tx_ready_out <= 1'b0;
            tx_st_q <= odm_pkg::st_start;
          end else begin
            tx_ready_out <= 1'b1;
          end
        end
        odm_pkg::st_start: if (tx_tick) begin
          tx_out <= 1'b0;
          tx_bit_q <= '0;
          tx_st_q <= odm_pkg::st_data;
        end
        odm_pkg::st_data: if (tx_tick) begin
          tx_out <= tx_shift_q[0];
          tx_shift_q <= {1'b0, tx_shift_q[`ODM_DATA_BITS-1:1]};
          tx_bit_q <= tx_bit_q + 3'h1;
          if (tx_bit_q == 3'h7) begin
            tx_st_q <= odm_pkg::st_stop;
          end
        end
        odm_pkg::st_stop: if (tx_tick) begin
          tx_out <= 1'b1;
          tx_st_q <= odm_pkg::st_idle;
        end
        default: tx_st_q <= odm_pkg::st_idle;
      endcase
    end
  end

  // Mid-bit sampling with no majority vote; a glitch at mid-bit corrupts the byte
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rx_st_q <= odm_pkg::st_idle;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_shift_q <= '0;
      rx_data_out <= '0;
      rx_valid_out <= 1'b0;
      rx_error_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      rx_error_out <= 1'b0;
      rx_cnt_q <= rx_cnt_q + 32'h0000_0001;
      case (rx_st_q)
        odm_pkg::st_idle: begin
          rx_cnt_q <= '0;
          if (!rx_in) begin
            rx_st_q <= odm_pkg::st_start;
          end
        end
        odm_pkg::st_start: if (rx_cnt_q == 32'(BIT_CYCLES / 2 - 1)) begin
          rx_cnt_q <= '0;
          rx_bit_q <= '0;
          rx_st_q <= rx_in ? odm_pkg::st_idle : odm_pkg::st_data;
        end
        odm_pkg::st_data: if (rx_cnt_q == 32'(BIT_CYCLES - 1)) begin
          rx_cnt_q <= '0;
          rx_shift_q <= {rx_in, rx_shift_q[`ODM_DATA_BITS-1:1]};
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == 3'h7) begin
            rx_st_q <= odm_pkg::st_stop;
          end
        end
        odm_pkg::st_stop: if (rx_cnt_q == 32'(BIT_CYCLES - 1)) begin
          rx_data_out <= rx_shift_q;
          rx_valid_out <= rx_in;
          rx_error_out <= ~rx_in;
          rx_st_q <= odm_pkg::st_idle;
        end
        default: rx_st_q <= odm_pkg::st_idle;
      endcase
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  AST_COUNT_STEP: assert property (sel_pulse |=> odo_count_out == $past(odo_count_out) + 1'b1)
    else $error("Count did not step on pulse");
  AST_OVER_SET: assert property (win_end && win_cnt_q > rate_limit |=> over_rate_out)
    else $error("Over-rate not flagged");
  AST_OVER_CLEAR: assert property (win_end && win_cnt_q <= rate_limit |=> !over_rate_out)
    else $error("Over-rate not cleared");
  AST_OVER_HOLD: assert property (!win_end |=> $stable(over_rate_out))
    else $error("Warning moved inside a window");
  AST_DIV_CLEAR: assert property (div_sel_in != div_sel_q |=> div_cnt_q == '0)
    else $error("Divider count not cleared on ratio change");
  AST_DIV_RANGE: assert property (div_cnt_q <= div_last(div_sel_q))
    else $error("Divider count beyond ratio");
  AST_FWD_FIRST: assert property (##1 fwd1_out == $past(div_q))
    else $error("First jack not forwarding divided signal");
  AST_FWD_SECOND: assert property (##1 fwd2_out == $past(odo1_in))
    else $error("Second jack not forwarding first input");
  AST_TX_START: assert property ($fell(tx_out) |-> $past(tx_st_q) == odm_pkg::st_start ||
      $past(tx_st_q) == odm_pkg::st_data && !$past(tx_shift_q[0]))
    else $error("Transmit line fell outside start bit");
  AST_TX_STOP: assert property (tx_st_q == odm_pkg::st_stop && tx_tick |=> tx_out)
    else $error("Stop bit not high");
  AST_RX_STOP: assert property (rx_valid_out |-> $past(rx_in) && !rx_error_out)
    else $error("Byte accepted without stop bit");

  COV_OVER_RATE: cover property ($rose(over_rate_out));
  COV_DIV_MAX: cover property (div_sel_q == 3'h7 && $fell(div_q));
  COV_TX_BYTE: cover property (tx_st_q == odm_pkg::st_stop ##1 tx_st_q == odm_pkg::st_idle);
  COV_RX_BYTE: cover property (rx_valid_out);
endmodule : odm_odometer_input

// File: odm_pulse_src.sv
// Pulse source model: a wheel transducer or speedometer signal on one jack
// Assumes clock_in is the block clock; the line moves just after rising edges
`timescale 1ns/10ps
module odm_pulse_src (
  input wire logic clock_in,
  output logic line_out
);
  // Pulled-up line idles high between pulses
  initial line_out = 1'b1;

  // Sends n pulses, each low for lo cycles then high for hi cycles
  task automatic pulses(input int n, input int lo, input int hi);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_in);
      line_out <= 1'b0;
      repeat (lo) @(posedge clock_in);
      line_out <= 1'b1;
      repeat (hi - 1) @(posedge clock_in);
    end
  endtask : pulses
endmodule : odm_pulse_src

// File: odm_odometer_input_test.sv
// Self-checking bench for the odometer pulse input block
// Assumes two pulse source models on the jacks; the bench drives settings and serial lines
`timescale 1ns/10ps
module odm_odometer_input_test;
  // Short window and bit time keep the run brief; limits become 0 slow and 1 fast
  localparam int W = 20000;
  localparam int B = 16;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic odo1, odo2, odo1_d, fwd1_d;
  logic active_sel = 1'b0, fast_limit = 1'b0, tx_valid = 1'b0, rx_line = 1'b1;
  logic [2:0] div_sel = 3'h0;
  logic [7:0] tx_data = 8'h00, rx_data;
  logic [31:0] count;
  logic count_pulse, over_rate, fwd1, fwd2, tx_line, tx_ready, rx_valid, rx_error;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0, npulse = 0, nfall = 0, nvalid = 0, nerr = 0;

  always #5 clock_in = ~clock_in;

  odm_pulse_src src1 (.clock_in(clock_in), .line_out(odo1));
  odm_pulse_src src2 (.clock_in(clock_in), .line_out(odo2));

  odm_odometer_input #(.WINDOW_CYCLES(W), .BIT_CYCLES(B)) dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .odo1_in(odo1), .odo2_in(odo2),
    .active_sel_in(active_sel), .fast_limit_in(fast_limit), .div_sel_in(div_sel),
    .tx_data_in(tx_data), .tx_valid_in(tx_valid), .rx_in(rx_line),
    .odo_count_out(count), .count_pulse_out(count_pulse), .over_rate_out(over_rate),
    .fwd1_out(fwd1), .fwd2_out(fwd2), .tx_out(tx_line), .tx_ready_out(tx_ready),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_error_out(rx_error)
  );

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Event tallies taken from the outputs, compared against expectations later
  always @(posedge clock_in) begin
    cyc <= sys_rst_in ? 0 : cyc + 1;
    odo1_d <= odo1;
    fwd1_d <= fwd1;
    if (count_pulse === 1'b1) npulse++;
    if (fwd1_d === 1'b1 && fwd1 === 1'b0) nfall++;
    if (rx_valid === 1'b1) nvalid++;
    if (rx_error === 1'b1) nerr++;
  end

  always @(negedge clock_in) begin
    if (cyc > 1) chk("fwd2", fwd2, odo1_d);
  end

  task automatic wait_cyc(input int c);
    while (cyc < c) @(posedge clock_in);
  endtask : wait_cyc

  task automatic t_rate;
    wait_cyc(1000);
    src1.pulses(1, 3, 3);
    wait_cyc(W + 20);
    chk("over_slow", over_rate, 1);
    fast_limit <= 1'b1;
    src1.pulses(1, 3, 3);
    wait_cyc(2 * W + 20);
    chk("over_fast_at_limit", over_rate, 0);
    src1.pulses(2, 3, 3);
    wait_cyc(3 * W + 20);
    chk("over_fast_above", over_rate, 1);
  endtask : t_rate

  task automatic t_count;
    int c0, p0;
    c0 = count;
    p0 = npulse;
    // One long 10 us low must count once; then back-to-back one-cycle pulses
    src1.pulses(1, 1000, 5);
    src1.pulses(8, 1, 1);
    repeat (5) @(posedge clock_in);
    @(negedge clock_in);
    chk("count", count - c0, 9);
    chk("count_pulses", npulse - p0, 9);
  endtask : t_count

  task automatic t_div;
    int c0, f0;
    active_sel <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      div_sel <= s[2:0];
      repeat (2) @(posedge clock_in);
      c0 = count;
      f0 = nfall;
      // A 157-cycle period sits far under the highest rate the divider accepts
      src2.pulses(2 ** s, 78, 79);
      repeat (6) @(posedge clock_in);
      chk("div_count", count - c0, 1);
      chk("fwd1_falls", nfall - f0, 1);
    end
    // Three of four edges, then a ratio change: the partial tally must go
    c0 = count;
    div_sel <= 3'h2;
    src2.pulses(3, 78, 79);
    div_sel <= 3'h3;
    src2.pulses(5, 78, 79);
    repeat (6) @(posedge clock_in);
    chk("div_cleared", count - c0, 0);
  endtask : t_div

  task automatic t_tx;
    logic [9:0] frame;
    int i;
    frame = {1'b1, 8'ha5, 1'b0};
    @(posedge clock_in);
    for (i = 0; i < 50 && tx_ready !== 1'b1; i++) @(posedge clock_in);
    tx_data <= 8'ha5;
    tx_valid <= 1'b1;
    @(posedge clock_in);
    tx_valid <= 1'b0;
    for (i = 0; i < 4 * B && tx_line !== 1'b0; i++) @(negedge clock_in);
    repeat (B / 2) @(negedge clock_in);
    for (int b = 0; b < 10; b++) begin
      chk("tx_bit", tx_line, frame[b]);
      repeat (B) @(negedge clock_in);
    end
    for (i = 0; i < 3 * B && tx_ready !== 1'b1; i++) @(negedge clock_in);
    chk("tx_ready", tx_ready, 1);
  endtask : t_tx

  task automatic send_frame(input logic [7:0] d, input logic stop);
    logic [9:0] bits;
    bits = {stop, d, 1'b0};
    @(posedge clock_in);
    for (int i = 0; i < 10; i++) begin
      rx_line <= bits[i];
      repeat (B) @(posedge clock_in);
    end
    rx_line <= 1'b1;
    repeat (2 * B) @(posedge clock_in);
  endtask : send_frame

  task automatic t_rx;
    int v0, e0;
    v0 = nvalid;
    e0 = nerr;
    send_frame(8'h3c, 1'b1);
    chk("rx_valid", nvalid - v0, 1);
    chk("rx_data", rx_data, 8'h3c);
    send_frame(8'hc3, 1'b0);
    chk("rx_error", nerr - e0, 1);
    chk("rx_valid_bad", nvalid - v0, 1);
  endtask : t_rx

  task automatic results;
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // Run needs about 101k cycles; the limit leaves some room
  initial begin
    #1200000;
    err_count++;
    results();
  end

  initial begin
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(negedge clock_in);
    chk("count_rst", count, 0);
    chk("tx_rst", tx_line, 1);
    chk("tx_ready_rst", tx_ready, 0);
    chk("over_rst", over_rate, 0);
    chk("fwd1_rst", fwd1, 1);
    // Counting fits in the first window; serial traffic shares the long rate windows
    t_count();
    fork
      t_rate();
      begin
        t_tx();
        t_rx();
      end
    join
    t_div();
    results();
  end
endmodule : odm_odometer_input_test
